// ===== common/mem_map_regs.svh
`ifndef MEM_MAP_REGS_SVH
`define MEM_MAP_REGS_SVH
// segment numbers used by the code map and the pc wrap
`define MM_SEG_TOP       8'hFF
`define MM_SEG_FE        8'hFE
`define MM_SEG_ONE       8'h01
`define MM_SEG_ZERO      8'h00
// 32 KB on-chip code at FF:0000-FF:7FFF
`define MM_ROM_AW        15
`define MM_TOP8_BASE     16'h7FF8
// upper 16 KB of region 00: mirrors upper half of the rom
`define MM_MIR_BASE      2'b11
`define MM_MIR_EXT_HI    2'b01
// data space: 32 byte register file, then 1 KB ram
`define MM_REGF_LAST     24'h00001F
`define MM_RAM_BASE      24'h000020
`define MM_RAM_LAST      24'h00041F
`define MM_RAM_AW        10
`define MM_BIT_LO        24'h000020
`define MM_BIT_HI        24'h0000FF
// configuration array at the top of external space
`define MM_CFG0_ADDR     24'hFFFFF8
`define MM_CFG1_ADDR     24'hFFFFF9
`define MM_MIRROR_BIT    1
`define MM_SYNC_WAIT     2'h3
// sfr addresses aliased onto register file entries
`define MM_SFR_ACC       8'hE0
`define MM_SFR_B         8'hF0
`define MM_SFR_SP        8'h81
`define MM_SFR_SPH       8'hBE
`define MM_SFR_DPL       8'h82
`define MM_SFR_DPH       8'h83
`define MM_SFR_DPXL      8'h84
`define MM_RF_ACC        6'h0B
`define MM_RF_B          6'h0A
`define MM_RF_SP         6'h3F
`define MM_RF_SPH        6'h3E
`define MM_RF_DPL        6'h3B
`define MM_RF_DPH        6'h3A
`define MM_RF_DPXL       6'h39
`endif

// ===== common/mem_map_pkg.sv
`default_nettype none
package mem_map_pkg;
   typedef enum logic {CODE_ROM = 1'b0, CODE_EXT = 1'b1} code_tgt_t;
   typedef enum logic [1:0] {DATA_REGF = 2'b00, DATA_RAM = 2'b01, DATA_EXT = 2'b10} data_tgt_t;
   typedef enum logic [1:0] {
      BOOT_SYNC = 2'b00,
      BOOT_CFG0 = 2'b01,
      BOOT_CFG1 = 2'b11,
      BOOT_RUN  = 2'b10
   } boot_st_t;
endpackage
`default_nettype wire

// ===== rtl/pc_wrap_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_regs.svh"
module pc_wrap_step (
   input  wire logic [23:0] pc,
   input  wire logic [2:0]  inc,
   output logic      [23:0] nxt
);
   logic [24:0] sum;
   logic [7:0]  seg;
   logic [7:0]  sum_seg;

   always_comb begin
      sum     = {1'b0, pc} + {22'h000000, inc};
      seg     = pc[23:16];
      sum_seg = sum[23:16];
      nxt     = sum[23:0];
      if (seg == `MM_SEG_TOP && sum_seg != `MM_SEG_TOP) begin
         nxt = {`MM_SEG_TOP, sum[15:0]};
      end
      else if (seg == `MM_SEG_ONE && sum_seg != `MM_SEG_ONE) begin
         nxt = {`MM_SEG_ZERO, sum[15:0]};
      end
      // FE: carries into FF: by plain addition
   end
endmodule
`default_nettype wire

// ===== rtl/mem_map_decoder.sv
// What this block does
// - access pin high: rom at FF:0000
// - pin high: code outside the rom and the 00: mirror window goes external
// - pin low: all code goes external
// - pin high: constant reads of top rom bytes stay internal
// - pc past FF: end loops to FF:0000
// - pc past FE: end continues at FF:0000
// - pc past 01: end wraps to 00:0000
// - 1 KB ram just above register file
// - ram bytes 20h to FFh bit addressable
// - code fetches never select data ram
// - mirror bit clear: upper rom in 00:
// - pin low: mirror window fetched from FF:4000
// - mirror bit set: no rom via 00:
// - unmapped data accesses go external
// - sfrs decoded in separate region S:
// - every sfr bit addressable
// - core sfrs alias register file entries
// - pin low: config bytes fetched externally
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_regs.svh"
module mem_map_decoder
   import mem_map_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        external_access_pin,
   input  wire logic [7:0]  rom_cfg_byte_one,
   output logic             cfg_rd_req,
   output logic      [23:0] cfg_rd_addr,
   input  wire logic        cfg_rd_ack,
   input  wire logic [7:0]  cfg_rd_data,
   output logic             map_ready,
   output logic             ea_high_q,
   output logic             onchip_code_mirror_disable_q,
   output logic      [7:0]  user_config_byte_zero_q,
   output logic      [7:0]  user_config_byte_one_q,
   input  wire logic        code_req,
   input  wire logic [23:0] code_addr,
   input  wire logic        code_const,
   output logic             code_vld_q,
   output code_tgt_t        code_tgt_q,
   output logic      [14:0] code_rom_addr_q,
   output logic      [23:0] code_ext_addr_q,
   output logic             code_top_zone_q,
   output logic             code_ext_stb,
   input  wire logic        pc_step_req,
   input  wire logic [23:0] pc_cur,
   input  wire logic [2:0]  pc_inc,
   output logic             pc_vld_q,
   output logic      [23:0] pc_next_q,
   input  wire logic        data_req,
   input  wire logic [23:0] data_addr,
   input  wire logic        data_bit,
   input  wire logic [2:0]  data_bit_idx,
   output logic             data_vld_q,
   output data_tgt_t        data_tgt_q,
   output logic      [4:0]  data_regf_idx_q,
   output logic      [9:0]  data_ram_addr_q,
   output logic      [23:0] data_ext_addr_q,
   output logic      [7:0]  data_bit_mask_q,
   output logic             data_bit_err_q,
   output logic             data_ext_stb,
   input  wire logic        sfr_req,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_bit,
   input  wire logic [2:0]  sfr_bit_idx,
   output logic             sfr_vld_q,
   output logic      [7:0]  sfr_sel_q,
   output logic             sfr_alias_q,
   output logic      [5:0]  sfr_regf_idx_q,
   output logic      [7:0]  sfr_bit_mask_q
);
   boot_st_t    st_q;
   logic        ea_meta_q;
   logic        ea_sync_q;
   logic [1:0]  wait_q;
   logic        code_go;
   logic        data_go;
   logic        sfr_go;
   code_tgt_t   code_tgt_d;
   logic [14:0] rom_addr_d;
   logic [23:0] ext_addr_d;
   logic        mir_win;
   logic        top8;
   data_tgt_t   data_tgt_d;
   logic        bit_ok;
   logic        alias_d;
   logic [5:0]  rf_idx_d;
   logic [23:0] pc_nxt;
   localparam logic [15:0] TOP8_BASE = `MM_TOP8_BASE;
   localparam logic [23:0] RAM_BASE  = `MM_RAM_BASE;

   assign map_ready    = (st_q == BOOT_RUN);
   assign code_go      = code_req && map_ready;
   assign data_go      = data_req && map_ready;
   assign sfr_go       = sfr_req && map_ready;
   assign code_ext_stb = code_vld_q && (code_tgt_q == CODE_EXT);
   assign data_ext_stb = data_vld_q && (data_tgt_q == DATA_EXT);
   assign cfg_rd_req   = (st_q == BOOT_CFG0) || (st_q == BOOT_CFG1);
   assign cfg_rd_addr  = (st_q == BOOT_CFG1) ? `MM_CFG1_ADDR : `MM_CFG0_ADDR;

   // pin comes from the board, two flops before use
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ea_meta_q <= 1'b0;
         ea_sync_q <= 1'b0;
      end else begin
         ea_meta_q <= external_access_pin;
         ea_sync_q <= ea_meta_q;
      end
   end

   // boot: wait for the synchroniser to settle, then read config
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q   <= BOOT_SYNC;
         wait_q <= 2'h0;
      end else begin
         case (st_q)
            BOOT_SYNC: begin
               wait_q <= wait_q + 2'h1;
               if (wait_q == `MM_SYNC_WAIT) begin
                  st_q <= ea_sync_q ? BOOT_RUN : BOOT_CFG0;
               end
            end
            BOOT_CFG0: begin
               if (cfg_rd_ack) begin
                  st_q <= BOOT_CFG1;
               end
            end
            BOOT_CFG1: begin
               if (cfg_rd_ack) begin
                  st_q <= BOOT_RUN;
               end
            end
            BOOT_RUN: st_q <= BOOT_RUN;
            default:  st_q <= BOOT_SYNC;
         endcase
      end
   end

   // map fixed once running, only reset reopens it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ea_high_q               <= 1'b0;
         user_config_byte_zero_q <= 8'hFF;
         user_config_byte_one_q  <= 8'hFF;
      end else begin
         if (st_q == BOOT_SYNC && wait_q == `MM_SYNC_WAIT) begin
            ea_high_q <= ea_sync_q;
            if (ea_sync_q) begin
               user_config_byte_one_q <= rom_cfg_byte_one;
            end
         end
         // only the first two bytes are kept
         if (st_q == BOOT_CFG0 && cfg_rd_ack) begin
            user_config_byte_zero_q <= cfg_rd_data;
         end
         if (st_q == BOOT_CFG1 && cfg_rd_ack) begin
            user_config_byte_one_q <= cfg_rd_data;
         end
      end
   end

   // erased config reads as ones, so the mirror stays off by default
   assign onchip_code_mirror_disable_q = user_config_byte_one_q[`MM_MIRROR_BIT];

   always_comb begin
      top8       = (code_addr[23:16] == `MM_SEG_TOP) && (code_addr[15:3] == TOP8_BASE[15:3]);
      mir_win    = !onchip_code_mirror_disable_q && (code_addr[23:16] == `MM_SEG_ZERO)
                   && (code_addr[15:14] == `MM_MIR_BASE);
      code_tgt_d = CODE_EXT;
      rom_addr_d = code_addr[14:0];
      ext_addr_d = code_addr;
      if (ea_high_q) begin
         // lower half of FF: is the rom
         if (code_addr[23:16] == `MM_SEG_TOP && !code_addr[15]) begin
            code_tgt_d = CODE_ROM;
         end
         // mirror window into upper 16 KB of rom
         else if (mir_win) begin
            code_tgt_d = CODE_ROM;
            rom_addr_d = {1'b1, code_addr[13:0]};
         end
         else begin
            code_tgt_d = CODE_EXT;
         end
      end else begin
         code_tgt_d = CODE_EXT;
         if (mir_win) begin
            ext_addr_d = {`MM_SEG_TOP, `MM_MIR_EXT_HI, code_addr[13:0]};
         end
      end
      // with the mirror disabled, 00: falls through to external
   end

   // code targets have no ram encoding at all
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         code_vld_q      <= 1'b0;
         code_tgt_q      <= CODE_EXT;
         code_rom_addr_q <= 15'h0000;
         code_ext_addr_q <= 24'h000000;
         code_top_zone_q <= 1'b0;
      end else begin
         code_vld_q <= code_go;
         if (code_go) begin
            code_tgt_q      <= code_tgt_d;
            code_rom_addr_q <= rom_addr_d;
            code_ext_addr_q <= ext_addr_d;
            // flag opcode fetches whose prefetch may run off chip
            code_top_zone_q <= top8 && ea_high_q && !code_const;
         end
      end
   end

   pc_wrap_step u_pc_step (
      .pc  (pc_cur),
      .inc (pc_inc),
      .nxt (pc_nxt)
   );

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pc_vld_q  <= 1'b0;
         pc_next_q <= 24'h000000;
      end else begin
         pc_vld_q <= pc_step_req;
         if (pc_step_req) begin
            pc_next_q <= pc_nxt;
         end
      end
   end

   always_comb begin
      bit_ok = (data_addr >= `MM_BIT_LO) && (data_addr <= `MM_BIT_HI);
      data_tgt_d = DATA_EXT;
      if (data_addr <= `MM_REGF_LAST) begin
         data_tgt_d = DATA_REGF;
      end
      // 1 KB ram above the register file
      else if (data_addr <= `MM_RAM_LAST) begin
         data_tgt_d = DATA_RAM;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         data_vld_q      <= 1'b0;
         data_tgt_q      <= DATA_EXT;
         data_regf_idx_q <= 5'h00;
         data_ram_addr_q <= 10'h000;
         data_ext_addr_q <= 24'h000000;
         data_bit_mask_q <= 8'h00;
         data_bit_err_q  <= 1'b0;
      end else begin
         data_vld_q <= data_go;
         if (data_go) begin
            data_tgt_q      <= data_tgt_d;
            data_regf_idx_q <= data_addr[4:0];
            // ram never goes above 41Fh, so low bits suffice
            data_ram_addr_q <= data_addr[9:0] - RAM_BASE[9:0];
            data_ext_addr_q <= data_addr;
            data_bit_mask_q <= (data_bit && bit_ok) ? (8'h01 << data_bit_idx) : 8'h00;
            data_bit_err_q  <= data_bit && !bit_ok;
         end
      end
   end

   always_comb begin
      // core registers share storage with the register file
      alias_d  = 1'b1;
      rf_idx_d = 6'h00;
      case (sfr_addr)
         `MM_SFR_ACC:  rf_idx_d = `MM_RF_ACC;
         `MM_SFR_B:    rf_idx_d = `MM_RF_B;
         `MM_SFR_SP:   rf_idx_d = `MM_RF_SP;
         `MM_SFR_SPH:  rf_idx_d = `MM_RF_SPH;
         `MM_SFR_DPL:  rf_idx_d = `MM_RF_DPL;
         `MM_SFR_DPH:  rf_idx_d = `MM_RF_DPH;
         `MM_SFR_DPXL: rf_idx_d = `MM_RF_DPXL;
         default:      alias_d  = 1'b0;
      endcase
   end

   // S: has its own request path, never the data map
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sfr_vld_q      <= 1'b0;
         sfr_sel_q      <= 8'h00;
         sfr_alias_q    <= 1'b0;
         sfr_regf_idx_q <= 6'h00;
         sfr_bit_mask_q <= 8'h00;
      end else begin
         sfr_vld_q <= sfr_go;
         if (sfr_go) begin
            sfr_sel_q      <= sfr_addr;
            sfr_alias_q    <= alias_d;
            sfr_regf_idx_q <= rf_idx_d;
            // no address restriction on sfr bit access
            sfr_bit_mask_q <= sfr_bit ? (8'h01 << sfr_bit_idx) : 8'h00;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   rom_map_a: assert property (
      code_go && ea_high_q && code_addr[23:15] == 9'h1FE
      |=> code_tgt_q == CODE_ROM && code_rom_addr_q == $past(code_addr[14:0]))
      else $error("rom window not decoded to rom");

   ext_route_a: assert property (
      code_go && ea_high_q && code_addr[23:16] != 8'hFF && code_addr[23:16] != 8'h00
      |=> code_ext_stb && code_ext_addr_q == $past(code_addr))
      else $error("code outside rom not external");

   ea_low_a: assert property (
      code_go && !ea_high_q |=> code_tgt_q == CODE_EXT && code_ext_stb)
      else $error("romless fetch reached rom");

   const_quiet_a: assert property (
      code_go && code_const && ea_high_q && code_addr[23:3] == 21'h1FEFFF
      |=> !code_ext_stb && !code_top_zone_q)
      else $error("constant read disturbed ports");

   pc_loop_a: assert property (
      pc_step_req && pc_cur == 24'hFFFFFF && pc_inc == 3'h1 |=> pc_next_q == 24'hFF0000)
      else $error("pc did not loop in FF:");

   pc_linear_a: assert property (
      pc_step_req && pc_cur == 24'hFEFFFE && pc_inc == 3'h2 |=> pc_next_q == 24'hFF0000)
      else $error("pc not linear from FE:");

   pc_low_a: assert property (
      pc_step_req && pc_cur[23:16] == 8'h01 && pc_cur[15:0] > 16'hFFF8
      |=> pc_next_q[23:16] != 8'h02)
      else $error("pc entered reserved area");

   ram_map_a: assert property (
      data_go && data_addr >= 24'h000020 && data_addr <= 24'h00041F
      |=> data_tgt_q == DATA_RAM && data_ram_addr_q == 10'($past(data_addr) - 24'h000020))
      else $error("ram window misdecoded");

   bit_range_a: assert property (
      data_go && data_bit |=> data_bit_err_q == ($past(data_addr) < 24'h000020
      || $past(data_addr) > 24'h0000FF))
      else $error("bit range check wrong");

   no_code_ram_a: assert property (
      code_go && code_addr >= 24'h000020 && code_addr <= 24'h00041F
      |=> code_ext_stb && code_ext_addr_q == $past(code_addr))
      else $error("code fetch selected ram");

   mirror_a: assert property (
      code_go && ea_high_q && !onchip_code_mirror_disable_q && code_addr[23:14] == 10'h003
      |=> code_tgt_q == CODE_ROM && code_rom_addr_q == {1'b1, $past(code_addr[13:0])})
      else $error("mirror window not in rom");

   mirror_ext_a: assert property (
      code_go && !ea_high_q && !onchip_code_mirror_disable_q && code_addr[23:14] == 10'h003
      |=> code_ext_addr_q == {10'h3FD, $past(code_addr[13:0])})
      else $error("mirror window external address wrong");

   no_mirror_a: assert property (
      code_go && onchip_code_mirror_disable_q && code_addr[23:16] == 8'h00 |=> code_ext_stb)
      else $error("rom reached through 00: while disabled");

   data_ext_a: assert property (
      data_go && data_addr > 24'h00041F |=> data_ext_stb && data_ext_addr_q == $past(data_addr))
      else $error("unmapped data not external");

   sfr_path_a: assert property (
      sfr_go && !data_go |=> sfr_vld_q && !data_vld_q && sfr_sel_q == $past(sfr_addr))
      else $error("sfr access leaked into data map");

   sfr_bit_a: assert property (
      sfr_go && sfr_bit |=> sfr_bit_mask_q == 8'(8'h01 << $past(sfr_bit_idx)))
      else $error("sfr bit mask wrong");

   alias_acc_a: assert property (
      sfr_go && sfr_addr == 8'hE0 |=> sfr_alias_q && sfr_regf_idx_q == 6'h0B)
      else $error("accumulator alias missing");

   cfg_fetch_a: assert property (
      st_q == BOOT_CFG0 && cfg_rd_ack |=> cfg_rd_req && cfg_rd_addr == 24'hFFFFF9)
      else $error("config fetch order wrong");

   map_hold_a: assert property (
      map_ready |=> map_ready && $stable(ea_high_q) && $stable(user_config_byte_one_q))
      else $error("address map changed after boot");
endmodule
`default_nettype wire

// ===== sim/ext_cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "mem_map_regs.svh"
module ext_cfg_mem (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        cfg_rd_req,
   input  wire logic [23:0] cfg_rd_addr,
   input  wire logic [3:0]  lat,
   input  wire logic [7:0]  byte_zero,
   input  wire logic [7:0]  byte_one,
   output logic             cfg_rd_ack,
   output logic      [7:0]  cfg_rd_data
);
   logic [3:0] wait_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wait_q      <= 4'h0;
         cfg_rd_ack  <= 1'b0;
         cfg_rd_data <= 8'h5A;
      end else begin
         cfg_rd_ack  <= 1'b0;
         // bus released: invert the data every cycle, so no byte holds steady
         cfg_rd_data <= ~cfg_rd_data;
         if (cfg_rd_req && !cfg_rd_ack) begin
            if (wait_q == lat) begin
               wait_q      <= 4'h0;
               cfg_rd_ack  <= 1'b1;
               if (cfg_rd_addr == `MM_CFG0_ADDR)
                  cfg_rd_data <= byte_zero;
               else if (cfg_rd_addr == `MM_CFG1_ADDR)
                  cfg_rd_data <= byte_one;
               else
                  cfg_rd_data <= 8'hA5;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mem_map_pkg::*;
   logic        core_clk, nrst, external_access_pin, cfg_rd_req, cfg_rd_ack, map_ready;
   logic        ea_high_q, onchip_code_mirror_disable_q, code_req, code_const, code_vld_q;
   logic        code_top_zone_q, code_ext_stb, pc_step_req, pc_vld_q, data_req, data_bit;
   logic        data_vld_q, data_bit_err_q, data_ext_stb, sfr_req, sfr_bit, sfr_vld_q, sfr_alias_q;
   logic [2:0]  pc_inc, data_bit_idx, sfr_bit_idx;
   logic [3:0]  lat;
   logic [4:0]  data_regf_idx_q;
   logic [5:0]  sfr_regf_idx_q;
   logic [7:0]  rom_cfg_byte_one, cfg_rd_data, user_config_byte_zero_q, user_config_byte_one_q;
   logic [7:0]  data_bit_mask_q, sfr_addr, sfr_sel_q, sfr_bit_mask_q;
   logic [9:0]  data_ram_addr_q;
   logic [14:0] code_rom_addr_q;
   logic [23:0] cfg_rd_addr, code_addr, code_ext_addr_q, pc_cur, pc_next_q, data_addr, data_ext_addr_q;
   code_tgt_t   code_tgt_q;
   data_tgt_t   data_tgt_q;
   int          errors, cmp_count, cyc;

   mem_map_decoder mem_map_decoder_i (
      .core_clk, .nrst, .external_access_pin, .rom_cfg_byte_one, .cfg_rd_req, .cfg_rd_addr,
      .cfg_rd_ack, .cfg_rd_data, .map_ready, .ea_high_q, .onchip_code_mirror_disable_q,
      .user_config_byte_zero_q, .user_config_byte_one_q, .code_req, .code_addr, .code_const,
      .code_vld_q, .code_tgt_q, .code_rom_addr_q, .code_ext_addr_q, .code_top_zone_q,
      .code_ext_stb, .pc_step_req, .pc_cur, .pc_inc, .pc_vld_q, .pc_next_q, .data_req,
      .data_addr, .data_bit, .data_bit_idx, .data_vld_q, .data_tgt_q, .data_regf_idx_q,
      .data_ram_addr_q, .data_ext_addr_q, .data_bit_mask_q, .data_bit_err_q, .data_ext_stb,
      .sfr_req, .sfr_addr, .sfr_bit, .sfr_bit_idx, .sfr_vld_q, .sfr_sel_q, .sfr_alias_q,
      .sfr_regf_idx_q, .sfr_bit_mask_q);

   ext_cfg_mem ext_cfg_mem_i (
      .core_clk, .nrst, .cfg_rd_req, .cfg_rd_addr, .lat, .byte_zero(8'h3C),
      .byte_one(rom_cfg_byte_one), .cfg_rd_ack, .cfg_rd_data);

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // generous ceiling; the whole run needs well under 1000 cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish;
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic boot(input logic pin, input logic [3:0] l, input logic [7:0] b1);
      int   n;
      logic seen;
      n = 0;
      seen = 1'b0;
      @(posedge core_clk);
      nrst <= 1'b0;
      external_access_pin <= pin;
      lat <= l;
      rom_cfg_byte_one <= b1;
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      code_req <= 1'b1;
      code_addr <= 24'hFF0000;
      while (map_ready !== 1'b1 && n < 60) begin
         @(posedge core_clk);
         #1;
         n++;
         chk(code_vld_q, 24'h0);
         if (cfg_rd_req === 1'b1 && !seen) begin
            seen = 1'b1;
            chk(cfg_rd_addr, 24'hFFFFF8);
         end
      end
      chk(map_ready, 24'h1);
      chk(seen, !pin);
      @(posedge core_clk);
      code_req <= 1'b0;
      @(posedge core_clk);
      #1;
      chk(ea_high_q, pin);
      chk(user_config_byte_zero_q, pin ? 24'hFF : 24'h3C);
      chk(user_config_byte_one_q, b1);
      chk(onchip_code_mirror_disable_q, b1[1]);
   endtask

   task automatic code_chk(input logic [23:0] a, input logic c, input code_tgt_t t,
                           input logic [23:0] ea, input logic top);
      @(posedge core_clk);
      code_req <= 1'b1;
      code_addr <= a;
      code_const <= c;
      @(posedge core_clk);
      code_req <= 1'b0;
      #1;
      chk(code_vld_q, 24'h1);
      chk(code_tgt_q, t);
      chk(code_ext_stb, t == CODE_EXT);
      chk(code_top_zone_q, top);
      if (t == CODE_ROM) begin
         chk(code_rom_addr_q, ea);
      end else begin
         chk(code_ext_addr_q, ea);
      end
   endtask

   task automatic dat_chk(input logic [23:0] a, input logic b, input logic [2:0] ix,
                          input data_tgt_t t, input logic [23:0] ev, input logic [7:0] m,
                          input logic e);
      @(posedge core_clk);
      data_req <= 1'b1;
      data_addr <= a;
      data_bit <= b;
      data_bit_idx <= ix;
      @(posedge core_clk);
      data_req <= 1'b0;
      #1;
      chk(data_vld_q, 24'h1);
      chk(data_tgt_q, t);
      chk(data_ext_stb, t == DATA_EXT);
      chk(data_bit_mask_q, m);
      chk(data_bit_err_q, e);
      case (t)
         DATA_REGF: chk(data_regf_idx_q, ev);
         DATA_RAM:  chk(data_ram_addr_q, ev);
         default:   chk(data_ext_addr_q, ev);
      endcase
   endtask

   task automatic sfr_all;
      logic [7:0] sa [8];
      logic [5:0] ri [8];
      sa = '{8'hE0, 8'hF0, 8'h81, 8'hBE, 8'h82, 8'h83, 8'h84, 8'h80};
      ri = '{6'h0B, 6'h0A, 6'h3F, 6'h3E, 6'h3B, 6'h3A, 6'h39, 6'h00};
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         sfr_req <= 1'b1;
         sfr_addr <= sa[i];
         sfr_bit <= 1'b1;
         sfr_bit_idx <= i[2:0];
         @(posedge core_clk);
         sfr_req <= 1'b0;
         #1;
         chk(sfr_vld_q, 24'h1);
         chk(sfr_sel_q, sa[i]);
         chk(sfr_bit_mask_q, 24'h1 << i);
         chk(sfr_alias_q, i < 7);
         chk(sfr_regf_idx_q, ri[i]);
      end
   endtask

   task automatic pc_chk(input logic [23:0] cur, input logic [2:0] inc, input logic [23:0] ex);
      @(posedge core_clk);
      pc_step_req <= 1'b1;
      pc_cur <= cur;
      pc_inc <= inc;
      @(posedge core_clk);
      pc_step_req <= 1'b0;
      #1;
      chk(pc_vld_q, 24'h1);
      chk(pc_next_q, ex);
   endtask

   initial begin
      errors = 0;
      cmp_count = 0;
      cyc = 0;
      nrst = 1'b0;
      external_access_pin = 1'b0;
      rom_cfg_byte_one = 8'hFF;
      lat = 4'h0;
      {code_req, code_const, pc_step_req, data_req, data_bit, sfr_req, sfr_bit} = 7'h00;
      {pc_inc, data_bit_idx, sfr_bit_idx, sfr_addr} = 17'h00000;
      {code_addr, pc_cur, data_addr} = 72'h0;
      boot(1'b0, 4'h2, 8'hFD);
      code_chk(24'hFF1234, 1'b0, CODE_EXT, 24'hFF1234, 1'b0);
      code_chk(24'hFF7FF8, 1'b0, CODE_EXT, 24'hFF7FF8, 1'b0);
      code_chk(24'h00C123, 1'b0, CODE_EXT, 24'hFF4123, 1'b0);
      boot(1'b1, 4'h0, 8'hFD);
      code_chk(24'hFF0000, 1'b0, CODE_ROM, 24'h0000, 1'b0);
      code_chk(24'hFF7FF7, 1'b0, CODE_ROM, 24'h7FF7, 1'b0);
      code_chk(24'hFF8000, 1'b0, CODE_EXT, 24'hFF8000, 1'b0);
      code_chk(24'h123456, 1'b0, CODE_EXT, 24'h123456, 1'b0);
      code_chk(24'h000020, 1'b0, CODE_EXT, 24'h000020, 1'b0);
      code_chk(24'h00C123, 1'b0, CODE_ROM, 24'h4123, 1'b0);
      code_chk(24'hFF7FF8, 1'b0, CODE_ROM, 24'h7FF8, 1'b1);
      code_chk(24'hFF7FFF, 1'b1, CODE_ROM, 24'h7FFF, 1'b0);
      dat_chk(24'h00001F, 1'b0, 3'h0, DATA_REGF, 24'h1F, 8'h00, 1'b0);
      dat_chk(24'h000020, 1'b1, 3'h3, DATA_RAM, 24'h000, 8'h08, 1'b0);
      dat_chk(24'h0000FF, 1'b1, 3'h7, DATA_RAM, 24'h0DF, 8'h80, 1'b0);
      dat_chk(24'h000100, 1'b1, 3'h1, DATA_RAM, 24'h0E0, 8'h00, 1'b1);
      dat_chk(24'h00041F, 1'b0, 3'h0, DATA_RAM, 24'h3FF, 8'h00, 1'b0);
      dat_chk(24'h000420, 1'b0, 3'h0, DATA_EXT, 24'h000420, 8'h00, 1'b0);
      dat_chk(24'hFF0010, 1'b0, 3'h0, DATA_EXT, 24'hFF0010, 8'h00, 1'b0);
      sfr_all;
      pc_chk(24'hFFFFFF, 3'h1, 24'hFF0000);
      pc_chk(24'hFFFFFE, 3'h3, 24'hFF0001);
      pc_chk(24'hFEFFFF, 3'h1, 24'hFF0000);
      pc_chk(24'hFEFFFE, 3'h2, 24'hFF0000);
      pc_chk(24'h01FFFF, 3'h2, 24'h000001);
      pc_chk(24'h001234, 3'h4, 24'h001238);
      @(posedge core_clk);
      external_access_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk(ea_high_q, 24'h1);
      code_chk(24'hFF1234, 1'b0, CODE_ROM, 24'h1234, 1'b0);
      boot(1'b1, 4'h0, 8'hFF);
      code_chk(24'h00C123, 1'b0, CODE_EXT, 24'h00C123, 1'b0);
      boot(1'b0, 4'h5, 8'hFF);
      code_chk(24'h00C123, 1'b0, CODE_EXT, 24'h00C123, 1'b0);
      tally_and_finish;
   end
endmodule
`default_nettype wire
